// >>> src/pqu_pipe.sv
// product/quotient unit: own pipeline beside the integer pipe
// How it works
// RULE1: unit stages advance freely; no integer stall input exists
// RULE2: 32x16 array; pass count chosen only from the secondary operand width
// RULE3: narrow products accepted every clock, wide ones every other clock
// RULE4: a wide product holds the next unit issue for one clock
// RULE5: operand size found from operand values by the unit itself
// RULE6: divide one quotient bit per clock, early-in skips zero-extended bytes
// RULE7: any unit instruction is held while a divide is active
// RULE8: dependent latency 1 for narrow, 2 (one held cycle) for wide
// RULE9: divide finishes after adjust plus 8..32 steps, plus sign fix if negative
// RULE10: register-file product stalls the integer pipe one or two cycles
// RULE11: an immediately dependent integer instruction adds one more stall
// RULE12: accumulates repeat every clock narrow, every two clocks wide
// RULE13: work starts at end of execute; stages parallel the integer ones
// RULE14: narrow product one clock per stage, wide one two multiply clocks
// RULE15: unit stages may skew; results only reach the result pair; register-file products go to gpr_result instead
// RULE16: instruction handed to the unit at the end of shared execute
// RULE17: product written into the result pair in the writeback stage
// RULE18: result reads wait, in order, until pending data is there
// RULE19: accumulate adds product to the pair, deduct subtracts it
// RULE20: register-file product goes to a general register, not the pair
// RULE21: loads to the pair reach a following accumulate with latency 1
`default_nettype none
module pqu_pipe (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        issue_valid,
   input  wire logic [3:0]  issue_op,
   input  wire logic [31:0] primary_operand,
   input  wire logic [31:0] secondary_operand,
   input  wire logic        next_uses_gpr,
   output logic             mdu_hold,
   output logic             pipe_stall,
   output logic             read_valid,
   output logic [31:0]      read_data,
   output logic             gpr_valid,
   output logic [31:0]      gpr_result,
   output logic             div_busy,
   output logic [31:0]      upper_result_register,
   output logic [31:0]      bottom_result_register
);

   function automatic logic pqu_is_unsigned(input logic [3:0] op);
      pqu_is_unsigned = (op == pqu_pkg::OP_PRODUCT_U) || (op == pqu_pkg::OP_ACCUM_U) ||
                        (op == pqu_pkg::OP_DEDUCT_U) || (op == pqu_pkg::OP_QUOTIENT_U);
   endfunction : pqu_is_unsigned

   function automatic logic pqu_is_product(input logic [3:0] op);
      pqu_is_product = (op <= pqu_pkg::OP_GPR_PRODUCT);
   endfunction : pqu_is_product

   logic        take;
   logic        op_u;
   logic [32:0] a_ext;
   logic [32:0] b_ext;
   logic        b_wide;
   logic        is_div;

   // M stage
   logic        m_valid;
   logic [3:0]  m_op;
   logic [32:0] m_a;
   logic [32:0] m_b;
   logic        m_wide;
   logic        m_second;
   logic [65:0] m_part;
   logic [16:0] seg;
   logic [49:0] pp;
   logic        m_first_wide;

   // A stage
   logic        a_valid;
   logic [3:0]  a_op;
   logic [63:0] a_prod;
   logic [31:0] a_opnd;

   // divider
   pqu_pkg::pqu_div_e div_state;
   logic [31:0] dv_a;
   logic [31:0] dv_b;
   logic        dv_sgn;
   logic        dv_neg_q;
   logic        dv_neg_r;
   logic        dv_fix;
   logic [32:0] dv_rem;
   logic [31:0] dv_quo;
   logic [5:0]  dv_cnt;
   logic        na;
   logic        nb;
   logic [31:0] abs_a;
   logic [31:0] abs_b;
   logic [5:0]  early_n;
   logic [32:0] trial;
   logic [32:0] st_rem;
   logic [31:0] st_quo;
   logic        div_start;
   logic        div_last;
   logic        div_wr;
   logic [31:0] div_hi;
   logic [31:0] div_lo;

   logic [1:0]  stall_cnt;
   logic [1:0]  next_stall_cnt;
   logic        next_hold;

   assign op_u   = pqu_is_unsigned(issue_op);
   assign a_ext  = {~op_u & primary_operand[31], primary_operand};
   assign b_ext  = {~op_u & secondary_operand[31], secondary_operand};
   // size comes from the value alone, no size field in the instruction
   assign b_wide = b_ext[32:16] != {17{b_ext[16]}}; // see RULE5 see RULE2
   assign is_div = (issue_op == pqu_pkg::OP_QUOTIENT) || (issue_op == pqu_pkg::OP_QUOTIENT_U);
   // handover at end of execute; held instructions stay with the integer pipe
   assign take      = issue_valid && !mdu_hold && !pipe_stall; // see RULE16 see RULE13
   assign div_start = take && is_div;

   // one 32x16 pass per clock; the wide case adds the upper half second
   always_comb begin
      if (m_second) begin
         seg = m_b[32:16];
      end else if (m_wide) begin
         seg = {1'b0, m_b[15:0]};
      end else begin
         seg = m_b[16:0];
      end
   end
   assign pp           = 50'($signed(m_a) * $signed(seg)); // see RULE2
   assign m_first_wide = m_valid && m_wide && !m_second;

   // no stall input reaches these stages; only a wide product holds the multiply stage a second clock
   always_ff @(posedge core_clk) begin // see RULE1
      if (sys_rst) begin
         m_valid  <= 1'b0;
         m_op     <= 4'h0;
         m_a      <= 33'h0;
         m_b      <= 33'h0;
         m_wide   <= 1'b0;
         m_second <= 1'b0;
         m_part   <= 66'h0;
      end else if (m_first_wide) begin
         // wide product stays a second clock in the multiply stage
         m_second <= 1'b1; // see RULE14 see RULE15
         m_part   <= {{16{pp[49]}}, pp};
      end else begin
         m_valid  <= take && !is_div;
         m_op     <= issue_op;
         m_a      <= a_ext;
         m_b      <= b_ext;
         m_wide   <= b_wide && pqu_is_product(issue_op); // see RULE14
         m_second <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         a_valid <= 1'b0;
         a_op    <= 4'h0;
         a_prod  <= 64'h0;
         a_opnd  <= 32'h0;
      end else begin
         a_valid <= m_valid && !m_first_wide; // see RULE14
         a_op    <= m_op;
         a_opnd  <= m_a[31:0];
         if (m_second) begin
            a_prod <= 64'(m_part + {pp, 16'h0000});
         end else begin
            a_prod <= 64'({{16{pp[49]}}, pp});
         end
      end
   end

   // divider datapath
   assign na    = dv_sgn && dv_a[31];
   assign nb    = dv_sgn && dv_b[31];
   assign abs_a = na ? 32'(-dv_a) : dv_a;
   assign abs_b = nb ? 32'(-dv_b) : dv_b;
   always_comb begin
      // early-in: skip steps over zero-extended upper bytes
      if (abs_a[31:8] == 24'h0) begin // see RULE6
         early_n = pqu_pkg::ITER_8;
      end else if (abs_a[31:16] == 16'h0) begin
         early_n = pqu_pkg::ITER_16;
      end else if (abs_a[31:24] == 8'h0) begin
         early_n = pqu_pkg::ITER_24;
      end else begin
         early_n = pqu_pkg::ITER_32;
      end
   end
   assign trial  = {dv_rem[31:0], dv_quo[31]} - {1'b0, dv_b};
   assign st_rem = trial[32] ? {dv_rem[31:0], dv_quo[31]} : trial;
   assign st_quo = {dv_quo[30:0], ~trial[32]}; // see RULE6
   // sign step only when an operand was negative
   assign div_last = ((div_state == pqu_pkg::DIV_ITER) && (dv_cnt == 6'h01) && !dv_fix) ||
                     (div_state == pqu_pkg::DIV_SIGN); // see RULE9

   always_comb begin
      div_wr = 1'b0;
      div_hi = st_rem[31:0];
      div_lo = st_quo;
      if (div_state == pqu_pkg::DIV_SIGN) begin
         div_wr = 1'b1;
         div_hi = dv_neg_r ? 32'(-dv_rem[31:0]) : dv_rem[31:0];
         div_lo = dv_neg_q ? 32'(-dv_quo) : dv_quo;
      end else if (div_last) begin
         div_wr = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_state <= pqu_pkg::DIV_IDLE;
         dv_a      <= 32'h0;
         dv_b      <= 32'h0;
         dv_sgn    <= 1'b0;
         dv_neg_q  <= 1'b0;
         dv_neg_r  <= 1'b0;
         dv_fix    <= 1'b0;
         dv_rem    <= 33'h0;
         dv_quo    <= 32'h0;
         dv_cnt    <= 6'h0;
      end else begin
         case (div_state)
            pqu_pkg::DIV_IDLE: begin
               if (div_start) begin
                  dv_a      <= primary_operand;
                  dv_b      <= secondary_operand;
                  dv_sgn    <= !op_u;
                  div_state <= pqu_pkg::DIV_ADJUST;
               end
            end
            pqu_pkg::DIV_ADJUST: begin
               // always taken, even when no negation is needed
               dv_b      <= abs_b;
               dv_quo    <= abs_a << (6'd32 - early_n);
               dv_rem    <= 33'h0;
               dv_cnt    <= early_n; // see RULE6
               dv_neg_q  <= na ^ nb;
               dv_neg_r  <= na;
               dv_fix    <= na | nb; // see RULE9
               div_state <= pqu_pkg::DIV_ITER;
            end
            pqu_pkg::DIV_ITER: begin
               dv_rem <= st_rem; // see RULE6
               dv_quo <= st_quo;
               dv_cnt <= dv_cnt - 6'h01;
               if (dv_cnt == 6'h01) begin
                  div_state <= dv_fix ? pqu_pkg::DIV_SIGN : pqu_pkg::DIV_IDLE;
               end
            end
            pqu_pkg::DIV_SIGN: begin
               div_state <= pqu_pkg::DIV_IDLE;
            end
            default: begin
               div_state <= pqu_pkg::DIV_IDLE;
            end
         endcase
      end
   end

   // result pair: writes land in program order from the align stage or the divider
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         upper_result_register  <= pqu_pkg::RESULT_RESET;
         bottom_result_register <= pqu_pkg::RESULT_RESET;
      end else if (div_wr) begin
         upper_result_register  <= div_hi; // see RULE9
         bottom_result_register <= div_lo;
      end else if (a_valid) begin
         case (a_op)
            pqu_pkg::OP_PRODUCT, pqu_pkg::OP_PRODUCT_U: begin
               {upper_result_register, bottom_result_register} <= a_prod; // see RULE17
            end
            pqu_pkg::OP_ACCUM, pqu_pkg::OP_ACCUM_U: begin
               {upper_result_register, bottom_result_register} <=
                  {upper_result_register, bottom_result_register} + a_prod; // see RULE19 see RULE12
            end
            pqu_pkg::OP_DEDUCT, pqu_pkg::OP_DEDUCT_U: begin
               {upper_result_register, bottom_result_register} <=
                  {upper_result_register, bottom_result_register} - a_prod; // see RULE19
            end
            // loads travel the same stages so a next accumulate sees them
            pqu_pkg::OP_LOAD_UPPER: begin
               upper_result_register <= a_opnd; // see RULE21
            end
            pqu_pkg::OP_LOAD_BOTTOM: begin
               bottom_result_register <= a_opnd; // see RULE21
            end
            default: begin
            end
         endcase
      end
   end

   // reads go down the pipe behind older writes, so they see final data
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         read_valid <= 1'b0;
         read_data  <= 32'h0;
      end else begin
         read_valid <= a_valid && ((a_op == pqu_pkg::OP_READ_UPPER) ||
                                   (a_op == pqu_pkg::OP_READ_BOTTOM)); // see RULE18
         read_data  <= (a_op == pqu_pkg::OP_READ_UPPER) ? upper_result_register
                                                        : bottom_result_register;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gpr_valid  <= 1'b0;
         gpr_result <= 32'h0;
      end else begin
         gpr_valid  <= a_valid && (a_op == pqu_pkg::OP_GPR_PRODUCT); // see RULE20
         gpr_result <= a_prod[31:0];
      end
   end

   // integer pipe stall that keeps the register-file write slot free
   always_comb begin
      if (take && (issue_op == pqu_pkg::OP_GPR_PRODUCT)) begin
         next_stall_cnt = (b_wide ? pqu_pkg::GPR_STALL_WIDE : pqu_pkg::GPR_STALL_NARROW) +
                          (next_uses_gpr ? pqu_pkg::GPR_STALL_DEP : 2'h0); // see RULE10 see RULE11
      end else if (stall_cnt != 2'h0) begin
         next_stall_cnt = stall_cnt - 2'h1;
      end else begin
         next_stall_cnt = 2'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stall_cnt  <= 2'h0;
         pipe_stall <= 1'b0;
      end else begin
         stall_cnt  <= next_stall_cnt;
         pipe_stall <= next_stall_cnt != 2'h0; // see RULE10
      end
   end

   // a wide product blocks the next clock; a divide blocks until written
   assign next_hold = (take && pqu_is_product(issue_op) && b_wide) || // see RULE4 see RULE3 see RULE8
                      div_start ||
                      ((div_state != pqu_pkg::DIV_IDLE) && !div_last); // see RULE7

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mdu_hold <= 1'b0;
         div_busy <= 1'b0;
      end else begin
         mdu_hold <= next_hold;
         div_busy <= div_start || ((div_state != pqu_pkg::DIV_IDLE) && !div_last);
      end
   end

endmodule : pqu_pipe
`default_nettype wire

// >>> src/pqu_pkg.sv
// shared constants and types for the product/quotient unit
`default_nettype none
package pqu_pkg;

   // instruction codes handed over at the end of the shared execute stage
   typedef enum logic [3:0] {
      OP_PRODUCT      = 4'h0,
      OP_PRODUCT_U    = 4'h1,
      OP_ACCUM        = 4'h2,
      OP_ACCUM_U      = 4'h3,
      OP_DEDUCT       = 4'h4,
      OP_DEDUCT_U     = 4'h5,
      OP_GPR_PRODUCT  = 4'h6,
      OP_QUOTIENT     = 4'h7,
      OP_QUOTIENT_U   = 4'h8,
      OP_READ_UPPER   = 4'h9,
      OP_READ_BOTTOM  = 4'ha,
      OP_LOAD_UPPER   = 4'hb,
      OP_LOAD_BOTTOM  = 4'hc
   } pqu_op_e;

   typedef enum logic [1:0] {
      DIV_IDLE   = 2'b00,
      DIV_ADJUST = 2'b01,
      DIV_ITER   = 2'b10,
      DIV_SIGN   = 2'b11
   } pqu_div_e;

   // early-in iteration counts by significant dividend width
   localparam logic [5:0] ITER_8  = 6'h08;
   localparam logic [5:0] ITER_16 = 6'h10;
   localparam logic [5:0] ITER_24 = 6'h18;
   localparam logic [5:0] ITER_32 = 6'h20;

   // integer pipe stall cycles for the register-file-targeted product
   localparam logic [1:0] GPR_STALL_NARROW = 2'h1;
   localparam logic [1:0] GPR_STALL_WIDE   = 2'h2;
   localparam logic [1:0] GPR_STALL_DEP    = 2'h1;

   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

endpackage : pqu_pkg
`default_nettype wire

// >>> test/pqu_issuer.sv
// integer pipe model: offers one instruction and keeps it up until the unit takes it
`default_nettype none
module pqu_issuer (
   input  wire logic        core_clk,
   input  wire logic        mdu_hold,
   input  wire logic        pipe_stall,
   output logic             issue_valid,
   output logic [3:0]       issue_op,
   output logic [31:0]      primary_operand,
   output logic [31:0]      secondary_operand,
   output logic             next_uses_gpr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      issue_valid = 1'b0;
      issue_op = 4'h0;
      primary_operand = 32'h5a5a_a5a5;
      secondary_operand = 32'ha5a5_5a5a;
      next_uses_gpr = 1'b0;
   end
   // entered just after a rising edge; returns at the edge that takes the offer
   task automatic send(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
                       input logic dep);
      logic ok;
      ok = 1'b0;
      issue_valid <= 1'b1;
      issue_op <= op;
      primary_operand <= a;
      secondary_operand <= b;
      next_uses_gpr <= dep;
      while (!ok) begin
         // hold and stall are registers, so the mid-cycle value is that edge's decision
         @(negedge core_clk);
         ok = !mdu_hold && !pipe_stall;
         @(posedge core_clk);
      end
   endtask : send
   // released operands show garbage, never the last value
   task automatic idle();
      issue_valid <= 1'b0;
      primary_operand <= ~primary_operand;
      secondary_operand <= ~secondary_operand;
   endtask : idle
endmodule : pqu_issuer
`default_nettype wire

// >>> test/pqu_pipe_monitor.sv
// port-level assertions for the product/quotient unit, bound into pqu_pipe
`default_nettype none
module pqu_pipe_monitor (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        issue_valid,
   input wire logic [3:0]  issue_op,
   input wire logic [31:0] primary_operand,
   input wire logic [31:0] secondary_operand,
   input wire logic        next_uses_gpr,
   input wire logic        mdu_hold,
   input wire logic        pipe_stall,
   input wire logic        read_valid,
   input wire logic [31:0] read_data,
   input wire logic        gpr_valid,
   input wire logic [31:0] gpr_result,
   input wire logic        div_busy,
   input wire logic [31:0] upper_result_register,
   input wire logic [31:0] bottom_result_register
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic take;
   logic narrow;
   logic wide;
   logic acc_op;
   logic gpr_op;
   assign take   = issue_valid && !mdu_hold && !pipe_stall;
   // values with 31:15 clear or 31:16 mixed are narrow/wide under either reading
   assign narrow = secondary_operand[31:15] == 17'h0;
   assign wide   = secondary_operand[31:16] != 16'h0 && secondary_operand[31:16] != 16'hffff;
   assign acc_op = issue_op <= pqu_pkg::OP_DEDUCT_U;
   assign gpr_op = issue_op == pqu_pkg::OP_GPR_PRODUCT;
   sequence s_stall_one;
      pipe_stall ##1 !pipe_stall ##1 gpr_valid;
   endsequence
   sequence s_stall_three;
      pipe_stall [*3] ##1 (!pipe_stall && gpr_valid);
   endsequence
   sequence s_div_byte;
      div_busy [*8] ##1 div_busy ##1 !div_busy;
   endsequence
   a_wide_hold: assert property (take && acc_op && wide |=> mdu_hold)
      else $error("no hold after wide product");
   a_narrow_free: assert property (take && acc_op && narrow |=> !mdu_hold)
      else $error("hold after narrow product");
   a_read_latency: assert property (take && (issue_op == pqu_pkg::OP_READ_UPPER ||
      issue_op == pqu_pkg::OP_READ_BOTTOM) |-> ##3 read_valid)
      else $error("read answer late or missing");
   a_gpr_narrow: assert property (take && gpr_op && narrow && !next_uses_gpr |=> s_stall_one)
      else $error("narrow register product stall wrong");
   a_gpr_wide_dep: assert property (take && gpr_op && wide && next_uses_gpr |=> s_stall_three)
      else $error("wide dependent register product stall wrong");
   a_div_byte_len: assert property (take && issue_op == pqu_pkg::OP_QUOTIENT_U &&
      primary_operand[31:8] == 24'h0 |=> s_div_byte)
      else $error("byte divide length wrong");
   a_busy_holds: assert property (div_busy |-> mdu_hold)
      else $error("issue open during divide");
   a_load_seen: assert property (take && issue_op == pqu_pkg::OP_LOAD_BOTTOM |->
      ##3 bottom_result_register == $past(primary_operand, 3))
      else $error("bottom load not visible");
endmodule : pqu_pipe_monitor
bind pqu_pipe pqu_pipe_monitor mon (.core_clk, .sys_rst, .issue_valid, .issue_op,
   .primary_operand, .secondary_operand, .next_uses_gpr, .mdu_hold, .pipe_stall, .read_valid,
   .read_data, .gpr_valid, .gpr_result, .div_busy, .upper_result_register,
   .bottom_result_register);
`default_nettype wire

// >>> test/pqu_pipe_test.sv
// self-checking bench for the product/quotient unit
`default_nettype none
module pqu_pipe_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        issue_valid, next_uses_gpr, mdu_hold, pipe_stall, read_valid, gpr_valid, div_busy;
   logic [3:0]  issue_op;
   logic [31:0] primary_operand, secondary_operand, read_data, gpr_result;
   logic [31:0] upper_result_register, bottom_result_register;
   logic [31:0] seed = 32'h296a;
   logic [63:0] pair = 64'h0;
   logic [31:0] rq[$];
   logic [31:0] gq[$];
   logic [3:0]  codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb, 4'hc};
   int          n_errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          busy_len = 0;
   logic [31:0] r, a, b;
   always #10 core_clk = ~core_clk;
   pqu_pipe dut (.core_clk, .sys_rst, .issue_valid, .issue_op, .primary_operand,
      .secondary_operand, .next_uses_gpr, .mdu_hold, .pipe_stall, .read_valid, .read_data,
      .gpr_valid, .gpr_result, .div_busy, .upper_result_register, .bottom_result_register);
   pqu_issuer iss (.core_clk, .mdu_hold, .pipe_stall, .issue_valid, .issue_op,
      .primary_operand, .secondary_operand, .next_uses_gpr);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // odd codes among the product family are the unsigned forms
   function automatic logic [63:0] prod(input logic [3:0] op, input logic [31:0] x, y);
      if (op[0]) return {32'h0, x} * {32'h0, y};
      return {{32{x[31]}}, x} * {{32{y[31]}}, y};
   endfunction : prod
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic op(input logic [3:0] c, input logic [31:0] x, y, input logic dep);
      case (c)
         pqu_pkg::OP_PRODUCT, pqu_pkg::OP_PRODUCT_U: pair = prod(c, x, y);
         pqu_pkg::OP_ACCUM, pqu_pkg::OP_ACCUM_U: pair = pair + prod(c, x, y);
         pqu_pkg::OP_DEDUCT, pqu_pkg::OP_DEDUCT_U: pair = pair - prod(c, x, y);
         pqu_pkg::OP_GPR_PRODUCT: gq.push_back(x * y);
         pqu_pkg::OP_QUOTIENT_U: pair = {x % y, x / y};
         pqu_pkg::OP_QUOTIENT: pair = {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))};
         pqu_pkg::OP_READ_UPPER: rq.push_back(pair[63:32]);
         pqu_pkg::OP_READ_BOTTOM: rq.push_back(pair[31:0]);
         pqu_pkg::OP_LOAD_UPPER: pair[63:32] = x;
         default: pair[31:0] = x;
      endcase
      iss.send(c, x, y, dep);
   endtask : op
   // pulses stand one cycle, so they are looked at mid-cycle
   always @(negedge core_clk) begin
      cycles++;
      if (read_valid === 1'b1) check("read_data", read_data, rq.pop_front());
      if (gpr_valid === 1'b1) check("gpr_result", gpr_result, gq.pop_front());
      if (div_busy === 1'b1) busy_len++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      check("pair after reset", {upper_result_register, bottom_result_register}, 64'h0);
      check("hold after reset", {mdu_hold, pipe_stall, div_busy}, 64'h0);
      $display("test reset done");
      @(posedge core_clk);
      op(pqu_pkg::OP_LOAD_BOTTOM, 32'hfedc_ba98, 32'h0, 1'b0);
      op(pqu_pkg::OP_LOAD_UPPER, 32'h0000_0007, 32'h0, 1'b0);
      op(pqu_pkg::OP_ACCUM, 32'hffff_fff0, 32'h0000_7fff, 1'b0);
      op(pqu_pkg::OP_DEDUCT_U, 32'hffff_ffff, 32'h0000_1234, 1'b0);
      op(pqu_pkg::OP_PRODUCT, 32'h8000_0001, 32'h7654_3210, 1'b0);
      op(pqu_pkg::OP_ACCUM, 32'h1234_5678, 32'h4321_0001, 1'b0);
      op(pqu_pkg::OP_READ_BOTTOM, 32'h0, 32'h0, 1'b0);
      op(pqu_pkg::OP_GPR_PRODUCT, 32'h0001_0003, 32'h0000_0101, 1'b0);
      op(pqu_pkg::OP_GPR_PRODUCT, 32'hc000_0005, 32'h0123_4567, 1'b1);
      op(pqu_pkg::OP_READ_UPPER, 32'h0, 32'h0, 1'b0);
      for (int i = 0; i < 80; i++) begin
         r = rnd();
         b = r[31] ? {1'b0, r[30:16] | 15'h1, r[15:0]} : {17'h0, r[14:0]};
         op(codes[r[7:0] % 11], rnd(), b, r[15]);
      end
      $display("test products done");
      // 40: signed with negative dividend, 48: signed with both operands positive
      for (int w = 8; w <= 48; w += 8) begin
         r = rnd();
         a = (w > 32) ? {24'h0, r[7:0] | 8'h80} : (r >> (32 - w)) | (32'h1 << (w - 1));
         if (w == 40) a = -a;
         busy_len = 0;
         op(w > 32 ? pqu_pkg::OP_QUOTIENT : pqu_pkg::OP_QUOTIENT_U, a,
            {24'h0, r[15:8] | 8'h1}, 1'b0);
         op(pqu_pkg::OP_READ_BOTTOM, 32'h0, 32'h0, 1'b0);
         op(pqu_pkg::OP_READ_UPPER, 32'h0, 32'h0, 1'b0);
         check("divide busy cycles", busy_len, w == 40 ? 10 : w > 32 ? 9 : w + 1);
      end
      iss.idle();
      repeat (6) @(negedge core_clk);
      check("pending answers", rq.size() + gq.size(), 64'h0);
      check("final pair", {upper_result_register, bottom_result_register}, pair);
      $display("test divides done");
      final_report();
   end
endmodule : pqu_pipe_test
`default_nettype wire
